//--- verif/clock_manager_monitor.sv
// Port checker for the delay-locked clock manager.
// Assumes the core clock is the only clock domain of the block.
`timescale 1ns/1ps
module clock_manager_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Observed ports
    input wire logic unit_reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic deskewed_clock_out,
    input wire logic doubled_clock_out,
    input wire logic locked,
    input wire logic config_done,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Reset, lock and startup hold
    a_reset_quiet_outputs: assert property (disable iff (1'b0) !resetn |=>
        !locked && !deskewed_clock_out && !doubled_clock_out && avs_waitrequest)
        else $error("outputs not quiet in reset");
    a_unit_reset_unlocks: assert property (unit_reset |=> !locked)
        else $error("lock kept after unit reset");
    a_done_after_lock: assert property (locked |=> config_done)
        else $error("done low while locked");
    a_done_low_unlocked: assert property (!config_done |-> $past(!locked))
        else $error("done low although locked");
    // Bus answer timing and contents
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus not answered in one cycle");
    a_wait_single_low: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_reads_zero: assert property (avs_read && avs_waitrequest
        && avs_address == 4'hc |=> avs_readdata == 32'h0) else $error("unmapped read");
    a_status_mirrors_lock: assert property (avs_read && avs_waitrequest
        && avs_address == 4'h4 |=> avs_readdata[0] == $past(locked)
        && avs_readdata[2] == $past(config_done)) else $error("status mismatch");
endmodule
bind delay_locked_clock_manager clock_manager_monitor mon_u (.core_clk(core_clk),
    .resetn(resetn), .unit_reset(unit_reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .deskewed_clock_out(deskewed_clock_out),
    .doubled_clock_out(doubled_clock_out), .locked(locked), .config_done(config_done),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

//--- verif/delay_locked_clock_manager_test.sv
// Self-checking bench for the delay-locked clock manager.
// Assumes the oscillator model and the bound port checker are compiled.
`timescale 1ns/1ps
module delay_locked_clock_manager_test;
    import clock_manager_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic unit_reset = 1'b0;
    logic pause = 1'b0;
    logic [11:0] period = 12'h10;
    logic [11:0] high_len = 12'h4;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic src;
    logic locked;
    logic config_done;
    logic [31:0] q;
    wire [5:0] clk_out;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    source_osc_model osc_u (.core_clk(core_clk), .resetn(resetn), .period(period),
        .high_len(high_len), .pause(pause), .source_clock_in(src));
    delay_locked_clock_manager dut_u (.core_clk(core_clk), .resetn(resetn),
        .source_clock_in(src), .unit_reset(unit_reset),
        .deskewed_clock_out(clk_out[0]), .quarter_phase_out(clk_out[1]),
        .half_phase_out(clk_out[2]), .three_quarter_phase_out(clk_out[3]),
        .doubled_clock_out(clk_out[4]), .divided_clock_out(clk_out[5]),
        .locked(locked), .config_done(config_done), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // Core clock and hang guard
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Cycles until the next rise of one output clock
    task automatic rise(input int i, output int c);
        logic p;
        c = 0;
        do begin
            p = clk_out[i];
            @(posedge core_clk);
            c++;
        end while (!(clk_out[i] === 1'b1 && p === 1'b0) && c < 2000);
    endtask
    task automatic hi(input int i, output int c);
        rise(i, c);
        c = 0;
        while (clk_out[i] === 1'b1 && c < 2000) begin
            @(posedge core_clk);
            c++;
        end
    endtask
    task automatic rises(input int len, output int m);
        logic p;
        m = 0;
        p = clk_out[0];
        repeat (len) begin
            @(posedge core_clk);
            if (clk_out[0] === 1'b1 && p === 1'b0) m++;
            p = clk_out[0];
        end
    endtask
    task automatic wait_lock();
        n = 0;
        while (locked !== 1'b1 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        chk(locked, 1);
    endtask
    task automatic pulse_reset();
        @(posedge core_clk);
        unit_reset <= 1'b1;
        @(posedge core_clk);
        unit_reset <= 1'b0;
        @(posedge core_clk);
        chk(locked, 0);
    endtask
    task automatic t_regs();
        bus(0, CTRL_OFFSET, 0);
        chk(q, 32'h11);
        bus(1, 4'hc, 32'hff);
        bus(0, 4'hc, 0);
        chk(q, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_lock();
        wait_lock();
        bus(0, STATUS_OFFSET, 0);
        chk(q, 32'h5);
        bus(0, PERIOD_OFFSET, 0);
        chk(q, 32'h10);
        for (int k = 1; k < 4; k++) begin
            rise(0, n);
            rise(k, n);
            chk(n, 4 * k);
        end
        hi(0, n);
        chk(n, 8);
        rise(4, n);
        rise(4, n);
        chk(n, 8);
        bus(1, CTRL_OFFSET, 32'h10);
        hi(0, n);
        hi(0, n);
        chk(n, 4);
        $display("test lock and phases done");
    endtask
    task automatic t_div();
        int h[8] = '{3, 4, 5, 6, 8, 10, 16, 32};
        for (int k = 0; k < 8; k++) begin
            bus(1, CTRL_OFFSET, 32'(k) << CTRL_DIV_LSB | 32'h1);
            rise(5, n);
            rise(5, n);
            rise(5, n);
            chk(n, (16 * h[k]) >> 1);
        end
        bus(1, CTRL_OFFSET, 32'h11);
        $display("test divider done");
    endtask
    // Delay one source period by a core cycle; the next period must realign
    task automatic t_shift();
        int c;
        c = 0;
        while (src !== 1'b1) @(posedge core_clk);
        while (src !== 1'b0) @(posedge core_clk);
        pause <= 1'b1;
        @(posedge core_clk);
        pause <= 1'b0;
        while (src !== 1'b1) @(posedge core_clk);
        while (src !== 1'b0) @(posedge core_clk);
        while (src !== 1'b1) @(posedge core_clk);
        while (clk_out[0] !== 1'b1) begin
            @(posedge core_clk);
            c++;
        end
        chk(c, 2);
        chk(locked, 1);
        $display("test phase shift done");
    endtask
    task automatic t_drift_pause();
        @(posedge core_clk);
        period <= 12'h11;
        repeat (120) @(posedge core_clk);
        chk(locked, 1);
        period <= 12'h10;
        pause <= 1'b1;
        rises(200, n);
        chk(n >= 1 && n <= 4, 1);
        chk(locked, 1);
        bus(0, STATUS_OFFSET, 0);
        chk(q, 32'h7);
        pause <= 1'b0;
        rises(16, n);
        chk(n, 0);
        rise(0, n);
        chk(n <= 64, 1);
        chk(locked, 1);
        $display("test drift and pause done");
    endtask
    task automatic t_hold();
        bus(1, CTRL_OFFSET, 32'h13);
        pulse_reset();
        repeat (2) @(posedge core_clk);
        chk(config_done, 0);
        bus(0, STATUS_OFFSET, 0);
        chk(q, 32'h0);
        repeat (48) @(posedge core_clk);
        hi(4, n);
        chk(n, 4);
        chk(locked, 0);
        wait_lock();
        repeat (2) @(posedge core_clk);
        chk(config_done, 1);
        bus(1, CTRL_OFFSET, 32'h11);
        period <= 12'h14;
        high_len <= 12'h5;
        pulse_reset();
        wait_lock();
        bus(0, PERIOD_OFFSET, 0);
        chk(q, 32'h14);
        rise(0, n);
        rise(1, n);
        chk(n, 5);
        $display("test hold and relock done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_lock();
        t_div();
        t_shift();
        t_drift_pause();
        t_hold();
        final_report();
    end
endmodule

//--- verif/source_osc_model.sv
// Source oscillator model for the clock manager's source clock input.
// Assumes the bench changes period, high time and pause after core edges.
`timescale 1ns/1ps
module source_osc_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Waveform control
    input wire logic [11:0] period,
    input wire logic [11:0] high_len,
    input wire logic pause,
    // Source clock
    output logic source_clock_in
);
    logic [11:0] cnt;
    // Counts the period; a pause only ever holds it in the low phase
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt <= 12'h0;
        end else if (!(pause && cnt >= high_len)) begin
            cnt <= (cnt + 12'h1 >= period) ? 12'h0 : cnt + 12'h1;
        end
    end
    // Restart resumes in the low phase, so a whole high period follows
    assign source_clock_in = resetn && cnt < high_len;
endmodule

//--- verilog/clock_manager_pkg.sv
// Shared constants for the delay-locked clock manager.
// Assumes a 40 MHz core clock and word registers on a 32-bit Avalon-MM slave.
package clock_manager_pkg;
    // Core clock and timing figures
    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int DRIFT_PS = 1000;
    localparam int DRIFT_CYC_RAW = (DRIFT_PS / 1000) * (CORE_CLK_HZ / 1_000_000) / 1000;
    localparam int DRIFT_CYC = (DRIFT_CYC_RAW < 1) ? 1 : DRIFT_CYC_RAW;
    localparam int STOP_LIMIT_US = 100;
    localparam int STOP_LIMIT_CYC = STOP_LIMIT_US * (CORE_CLK_HZ / 1_000_000);
    localparam int LOCK_PERIODS = 16;
    localparam int FLUSH_PERIODS = 2;
    localparam int FILL_PERIODS = 2;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] PERIOD_OFFSET = 4'h8;

    // Control field positions
    localparam int CTRL_DUTY_BIT = 0;
    localparam int CTRL_WAIT_BIT = 1;
    localparam int CTRL_RESET_BIT = 2;
    localparam int CTRL_DIV_LSB = 4;
    localparam int DIV_CODE_W = 3;

    // Control reset values: correction on, no startup hold, ratio 2
    localparam logic CTRL_DUTY_RESET = 1'b1;
    localparam logic CTRL_WAIT_RESET = 1'b0;
    localparam logic [2:0] DIV_CODE_RESET = 3'h1;

    // Status field positions
    localparam int STATUS_LOCK_BIT = 0;
    localparam int STATUS_PAUSE_BIT = 1;
    localparam int STATUS_DONE_BIT = 2;

    // Divide codes 0..7 give ratios 1.5, 2, 2.5, 3, 4, 5, 8, 16
    typedef enum logic [2:0] {
        DIV_1P5 = 3'h0, DIV_2 = 3'h1, DIV_2P5 = 3'h2, DIV_3 = 3'h3,
        DIV_4 = 3'h4, DIV_5 = 3'h5, DIV_8 = 3'h6, DIV_16 = 3'h7
    } divide_ratio_option_t;
endpackage

//--- verilog/delay_locked_clock_manager.sv
// Delay-locked clock manager: measures the source clock and rebuilds phase,
// doubled and divided outputs from the core clock, with lock indication.
// Assumes source_clock_in is synchronous to core_clk and much slower than it.
//
// Contract
// - Default 1x outputs corrected to 50/50
// - Correction off: 1x follows source duty
// - Divided output is 1x over ratio
// - Startup hold keeps done low until locked
// - Lock holds across period drift up to 1ns
// - Lock stays asserted through legal pause
// - Flush then fill outputs around pause
// - Input phase shift reproduced one to four clocks later
// - Reset drops lock within four source cycles
// - Doubled output is 25/75 copy before lock
// - Phase outputs lag by quarter, half, three-quarters
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module delay_locked_clock_manager
    import clock_manager_pkg::*;
#(
    parameter int PERIOD_W = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Source clock and unit reset
    input wire logic source_clock_in,
    input wire logic unit_reset,
    // Rebuilt clocks
    output logic deskewed_clock_out,
    output logic quarter_phase_out,
    output logic half_phase_out,
    output logic three_quarter_phase_out,
    output logic doubled_clock_out,
    output logic divided_clock_out,
    // Status
    output logic locked,
    output logic config_done,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import clock_manager_pkg::*;

    localparam int DIV_W = PERIOD_W + 5;

    // Control state
    logic duty_correct;
    logic startup_wait;
    logic soft_reset;
    logic [DIV_CODE_W-1:0] div_code;
    // Measurement state
    logic src_prev;
    logic [PERIOD_W-1:0] since_rise;
    logic [PERIOD_W-1:0] period_ref;
    logic [PERIOD_W-1:0] high_len;
    logic [4:0] stable_cnt;
    logic paused;
    logic [12:0] pause_cnt;
    logic [1:0] flush_cnt;
    logic [1:0] fill_cnt;
    // Output generators
    logic [PERIOD_W-1:0] ph;
    logic [DIV_W-1:0] dv_cnt;
    logic [DIV_W-1:0] div_len;
    logic src_rise;
    logic src_fall;
    logic dll_rst;
    logic out_on;
    logic [PERIOD_W-1:0] half;
    logic [PERIOD_W-1:0] quarter;
    logic [PERIOD_W-1:0] meas;
    logic meas_ok;
    logic bus_take;

    // Half-steps of the divide ratio
    function automatic logic [5:0] ratio_halves(input logic [DIV_CODE_W-1:0] code);
        unique case (divide_ratio_option_t'(code))
            DIV_1P5: ratio_halves = 6'h03;
            DIV_2: ratio_halves = 6'h04;
            DIV_2P5: ratio_halves = 6'h05;
            DIV_3: ratio_halves = 6'h06;
            DIV_4: ratio_halves = 6'h08;
            DIV_5: ratio_halves = 6'h0a;
            DIV_8: ratio_halves = 6'h10;
            DIV_16: ratio_halves = 6'h20;
        endcase
    endfunction

    // One 1x phase: position shifted back by an offset, high for half or source high time
    function automatic logic phase_level(input logic [PERIOD_W-1:0] pos,
                                         input logic [PERIOD_W-1:0] off,
                                         input logic [PERIOD_W-1:0] per,
                                         input logic dcc,
                                         input logic [PERIOD_W-1:0] hi);
        logic [PERIOD_W-1:0] p;
        p = (pos >= off) ? pos - off : pos + per - off;
        phase_level = dcc ? (p < (per >> 1)) : (p < hi);
    endfunction

    // Combined unit reset from pin and register, edges of the source
    assign dll_rst = unit_reset | soft_reset;
    assign src_rise = source_clock_in & ~src_prev;
    assign src_fall = ~source_clock_in & src_prev;
    assign half = period_ref >> 1;
    assign quarter = period_ref >> 2;
    assign meas = since_rise + 1'b1;
    assign meas_ok = (meas >= period_ref ? meas - period_ref : period_ref - meas)
                     <= PERIOD_W'(DRIFT_CYC);
    assign out_on = (flush_cnt != 2'h0 || !paused) && fill_cnt == 2'h0;
    assign div_len = DIV_W'((DIV_W'(period_ref) * DIV_W'(ratio_halves(div_code))) >> 1);
    assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;

    // Source edge history
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= source_clock_in;
        end
    end

    // Period and high-time measurement
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst) begin
            since_rise <= '0;
            period_ref <= '0;
            high_len <= '0;
        end else begin
            if (src_rise) begin
                since_rise <= '0;
                if (!paused && !meas_ok) begin
                    period_ref <= meas;
                end
            end else if (since_rise != {PERIOD_W{1'b1}}) begin
                since_rise <= since_rise + 1'b1;
            end
            if (src_fall && !paused) begin
                high_len <= meas;
            end
        end
    end

    // Lock acquisition; a drift within tolerance keeps the count
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst) begin
            stable_cnt <= '0;
            locked <= 1'b0;
        end else if (paused && pause_cnt >= 13'(STOP_LIMIT_CYC)) begin
            stable_cnt <= '0;
            locked <= 1'b0;
        end else if (src_rise && !paused) begin
            if (meas_ok && period_ref != '0) begin
                if (stable_cnt != 5'(LOCK_PERIODS)) begin
                    stable_cnt <= stable_cnt + 1'b1;
                end else begin
                    locked <= 1'b1;
                end
            end else begin
                stable_cnt <= '0;
                locked <= 1'b0;
            end
        end
    end

    // Pause detection only once locked: a stale first period must not stall acquisition
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst) begin
            paused <= 1'b0;
            pause_cnt <= '0;
        end else if (src_rise) begin
            paused <= 1'b0;
            pause_cnt <= '0;
        end else if (locked && !source_clock_in && period_ref != '0 &&
                     since_rise > period_ref + PERIOD_W'(DRIFT_CYC)) begin
            paused <= 1'b1;
            if (pause_cnt != 13'h1fff) begin
                pause_cnt <= pause_cnt + 1'b1;
            end
        end
    end

    // Flush a few output clocks at a stop, then suppress some after restart
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst) begin
            flush_cnt <= 2'(FLUSH_PERIODS);
            fill_cnt <= '0;
        end else begin
            if (!paused) begin
                flush_cnt <= 2'(FLUSH_PERIODS);
            end else if (ph == period_ref - 1'b1 && flush_cnt != 2'h0) begin
                flush_cnt <= flush_cnt - 1'b1;
            end
            if (src_rise && paused) begin
                fill_cnt <= 2'(FILL_PERIODS);
            end else if (src_rise && fill_cnt != 2'h0) begin
                fill_cnt <= fill_cnt - 1'b1;
            end
        end
    end

    // Phase position; realigned at each source rise so shifts pass through
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst) begin
            ph <= '0;
        end else if (src_rise || ph + 1'b1 >= period_ref) begin
            ph <= '0;
        end else begin
            ph <= ph + 1'b1;
        end
    end

    // 1x phase outputs
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst || period_ref == '0) begin
            deskewed_clock_out <= 1'b0;
            quarter_phase_out <= 1'b0;
            half_phase_out <= 1'b0;
            three_quarter_phase_out <= 1'b0;
        end else begin
            deskewed_clock_out <= out_on &
                phase_level(ph, '0, period_ref, duty_correct, high_len);
            quarter_phase_out <= out_on &
                phase_level(ph, quarter, period_ref, duty_correct, high_len);
            half_phase_out <= out_on &
                phase_level(ph, half, period_ref, duty_correct, high_len);
            three_quarter_phase_out <= out_on &
                phase_level(ph, half + quarter, period_ref, duty_correct, high_len);
        end
    end

    // Doubled output: 25/75 copy before lock, two 50/50 pulses per period after
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst || period_ref == '0) begin
            doubled_clock_out <= 1'b0;
        end else if (!locked) begin
            doubled_clock_out <= out_on & (ph < quarter);
        end else begin
            doubled_clock_out <= out_on &
                ((ph < quarter) | (ph >= half && ph < half + quarter));
        end
    end

    // Divided output: period scaled by the ratio, always 50/50
    always_ff @(posedge core_clk) begin
        if (!resetn || dll_rst || period_ref == '0) begin
            dv_cnt <= '0;
            divided_clock_out <= 1'b0;
        end else begin
            dv_cnt <= (dv_cnt + 1'b1 >= div_len) ? '0 : dv_cnt + 1'b1;
            divided_clock_out <= out_on & (dv_cnt < (div_len >> 1));
        end
    end

    // Configuration-done with optional hold until lock
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            config_done <= 1'b0;
        end else begin
            config_done <= ~startup_wait | locked;
        end
    end

    // Bus: one wait cycle, then answer with waitrequest low for one cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else if ((avs_read | avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= '0;
            if (avs_read) begin
                unique case (avs_address)
                    CTRL_OFFSET: begin
                        avs_readdata[CTRL_DUTY_BIT] <= duty_correct;
                        avs_readdata[CTRL_WAIT_BIT] <= startup_wait;
                        avs_readdata[CTRL_RESET_BIT] <= soft_reset;
                        avs_readdata[CTRL_DIV_LSB +: DIV_CODE_W] <= div_code;
                    end
                    STATUS_OFFSET: begin
                        avs_readdata[STATUS_LOCK_BIT] <= locked;
                        avs_readdata[STATUS_PAUSE_BIT] <= paused;
                        avs_readdata[STATUS_DONE_BIT] <= config_done;
                    end
                    PERIOD_OFFSET: avs_readdata[PERIOD_W-1:0] <= period_ref;
                    default: avs_readdata <= '0;
                endcase
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Control register write, taken at the answering edge
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            duty_correct <= CTRL_DUTY_RESET;
            startup_wait <= CTRL_WAIT_RESET;
            soft_reset <= 1'b0;
            div_code <= DIV_CODE_RESET;
        end else if (bus_take && avs_write && avs_address == CTRL_OFFSET) begin
            duty_correct <= avs_writedata[CTRL_DUTY_BIT];
            startup_wait <= avs_writedata[CTRL_WAIT_BIT];
            soft_reset <= avs_writedata[CTRL_RESET_BIT];
            div_code <= avs_writedata[CTRL_DIV_LSB +: DIV_CODE_W];
        end
    end
endmodule
